//--- core/irqtb_params.svh
/*
 Offsets, field positions, reset values and counts of the interrupt collector.
 Assumes inclusion by core/irqtb_top.sv only.
*/
// What this block does
// [RULE1] Fault flag is set while the fault pin is low.
// [RULE2] Servicing fault clears its flag and the master enable.
// [RULE3] Pause flag sets on rising, falling or both pause pin edges.
// [RULE4] Pause service clears flag and master enable; call needs enables, stack room.
// [RULE5] PWM duty and period matches set flags feeding a group.
// [RULE6] PWM service clears group flag and master enable; software clears sources.
// [RULE7] Time base overflow sets its flag; service clears it and master enable.
// [RULE8] Control bit 7 switches the time base divider on or off.
// [RULE9] Control bit 6 picks dedicated clock or system clock over four.
// [RULE10] Bits 5:4 select 4096, 8192, 16384 or 32768 input ticks.
// [RULE11] Control bits 3:0 read as zero.
// [RULE12] Capture overflow and compare set flags in a group.
// [RULE13] Capture call needs three enables; service clears group flag only. The code's service also clears the master enable.
// [RULE14] Each compact timer has two match flags, each enabled, raising group.
// [RULE15] Timer call needs master, source and group enables; uses group vector.
// [RULE16] Software clears timer match flags after service.
// [RULE17] Remote rise, fall and overflow set three flags in a group.
// [RULE18] Software clears remote flags after service.
// [RULE19] Nonvolatile cycle end sets flag; call needs three enables.
// [RULE20] Software clears nonvolatile done flag after service.
// [RULE21] Low supply detection sets a flag routed to a group.
// [RULE22] Software clears low supply flag after service.
// [RULE23] A set flag stays set until serviced or cleared by software.
// [RULE24] A disabled time base holds its divider at zero.
`ifndef IRQTB_PARAMS_SVH
`define IRQTB_PARAMS_SVH
// register byte offsets
`define IRQTB_OFS_CTRL    8'h00
`define IRQTB_OFS_GRP_EN  8'h04
`define IRQTB_OFS_SRC_EN  8'h08
`define IRQTB_OFS_SRC_FL  8'h0C
`define IRQTB_OFS_STATUS  8'h10
`define IRQTB_OFS_TBC     8'h14
`define IRQTB_OFS_CALL    8'h18
// source flag / enable bit positions
`define IRQTB_SRC_PWMD    0
`define IRQTB_SRC_PWMP    1
`define IRQTB_SRC_CAPO    2
`define IRQTB_SRC_CAPC    3
`define IRQTB_SRC_RRISE   4
`define IRQTB_SRC_RFALL   5
`define IRQTB_SRC_ROVF    6
`define IRQTB_SRC_NVM     7
`define IRQTB_SRC_LOWV    8
`define IRQTB_SRC_TMRP    16
`define IRQTB_SRC_TMRA    24
// time base control fields and reset
`define IRQTB_TBC_ON      3
`define IRQTB_TBC_CK      2
`define IRQTB_TBC_RST     4'h3
`define IRQTB_TB_BASE     4096
`define IRQTB_SYS_DIV     2'h3
// call vectors, lowest priority first
`define IRQTB_VECTORS     {6'h3C, 6'h34, 6'h2C, 6'h28, 6'h24, 6'h20, 6'h1C, 6'h18}
`define IRQTB_RESP_OK     2'h0
`define IRQTB_RESP_ERR    2'h2
`endif

//--- core/irqtb_pkg.sv
/*
 Types of the interrupt collector: bus carriers and register state.
 Assumes an AXI4-Lite master with 8-bit byte addresses.
*/
package irqtb_pkg;
    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } irqtb_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } irqtb_axi_rsp_t;

    // one-cycle peripheral events on the core clock
    typedef struct packed {
        logic pwm_duty_match;
        logic pwm_period_match;
        logic capture_overflow;
        logic capture_compare;
        logic remote_timer_overflow;
        logic nvm_cycle_done;
    } irqtb_evt_t;

    typedef struct packed {
        logic [1:0]  fault_s;
        logic [1:0]  pause_s;
        logic [1:0]  rx_s;
        logic [1:0]  lowv_s;
        logic [1:0]  tbclk_s;
        logic        pause_d;
        logic        rx_d;
        logic        lowv_d;
        logic        tbclk_d;
        logic        global_master_enable;
        logic [2:0]  ind_en;
        logic [1:0]  pause_mode;
        logic [4:0]  group_irq_enable;
        logic [4:0]  group_req_flag;
        logic [2:0]  ind_flag;
        logic [31:0] src_en;
        logic [31:0] src_flag;
        logic [3:0]  time_base_control;
        logic [1:0]  pre4;
        logic [15:0] tb_cnt;
        logic        call;
        logic [2:0]  call_idx;
        logic [5:0]  call_vec;
        logic        aw_full;
        logic [7:0]  aw_addr;
        logic        w_full;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        irqtb_axi_rsp_t rsp;
    } irqtb_state_t;
endpackage

//--- core/irqtb_top.sv
/*
 Interrupt request collector with time base divider and AXI4-Lite registers.
 Assumes event pulses on core_clk, pins asynchronous, CPU acks each call once.
*/
`timescale 1ns/1ps
`include "irqtb_params.svh"

module irqtb_top
    import irqtb_pkg::*;
#(
    parameter int          N_TIMERS = 5,
    parameter logic [15:0] TB_BASE  = 16'(`IRQTB_TB_BASE)
) (
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    input  wire irqtb_axi_req_t      axi_req,
    output irqtb_axi_rsp_t           axi_rsp,
    input  wire logic                fault_pin_n,
    input  wire logic                pause_pin,
    input  wire logic                remote_rx_pin,
    input  wire logic                low_supply_det,
    input  wire logic                dedicated_timebase_clock,
    input  wire irqtb_evt_t          evt,
    input  wire logic [N_TIMERS-1:0] timer_period_match,
    input  wire logic [N_TIMERS-1:0] timer_second_match,
    input  wire logic                stack_full,
    input  wire logic                svc_ack,
    input  wire logic                reti,
    output logic                     irq_call,
    output logic [5:0]               irq_vector
);
    // group index of each group flag
    localparam int G_PWM = 0;
    localparam int G_CAP = 1;
    localparam int G_TMR = 2;
    localparam int G_RMT = 3;
    localparam int G_MSC = 4;
    localparam logic [47:0] VEC = `IRQTB_VECTORS;

    irqtb_state_t st_r;
    irqtb_state_t st_nxt;

    // lowest index wins
    function automatic logic [2:0] pick(input logic [7:0] r);
        logic [2:0] k;
        k = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (r[i]) begin
                k = 3'(i);
            end
        end
        return k;
    endfunction

    function automatic logic [31:0] lanes(input logic [3:0] s);
        return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    //----------------------------------------------------------------
    // source events
    //----------------------------------------------------------------
    logic [31:0] src_set;
    logic [4:0]  grp_set;
    logic        tb_tick;
    logic        tb_ovf;
    logic        pause_edge;
    logic [15:0] tb_lim;
    logic [7:0]  req;
    logic [31:0] wmask;
    logic        wr_go;
    logic        tb_on;

    always_comb begin
        src_set = 32'h0000_0000;
        src_set[`IRQTB_SRC_PWMD]  = evt.pwm_duty_match;                      // RULE5
        src_set[`IRQTB_SRC_PWMP]  = evt.pwm_period_match;                    // RULE5
        src_set[`IRQTB_SRC_CAPO]  = evt.capture_overflow;                    // RULE12
        src_set[`IRQTB_SRC_CAPC]  = evt.capture_compare;                     // RULE12
        src_set[`IRQTB_SRC_RRISE] = st_r.rx_s[1] & ~st_r.rx_d;               // RULE17
        src_set[`IRQTB_SRC_RFALL] = ~st_r.rx_s[1] & st_r.rx_d;               // RULE17
        src_set[`IRQTB_SRC_ROVF]  = evt.remote_timer_overflow;               // RULE17
        src_set[`IRQTB_SRC_NVM]   = evt.nvm_cycle_done;                      // RULE19
        src_set[`IRQTB_SRC_LOWV]  = st_r.lowv_s[1] & ~st_r.lowv_d;           // RULE21
        for (int t = 0; t < N_TIMERS; t++) begin
            src_set[`IRQTB_SRC_TMRP + t] = timer_period_match[t];            // RULE14
            src_set[`IRQTB_SRC_TMRA + t] = timer_second_match[t];            // RULE14
        end
    end

    // enabled source events raise their group
    always_comb begin
        logic [31:0] e;
        e = src_set & st_r.src_en;
        grp_set[G_PWM] = |e[1:0];                                            // RULE5
        grp_set[G_CAP] = |e[3:2];                                            // RULE12
        grp_set[G_TMR] = |e[31:16];                                          // RULE14
        grp_set[G_RMT] = |e[6:4];                                            // RULE17
        grp_set[G_MSC] = |e[8:7];                                            // RULE19 RULE21
    end

    assign pause_edge = (st_r.pause_mode[0] & st_r.pause_s[1] & ~st_r.pause_d)
                      | (st_r.pause_mode[1] & ~st_r.pause_s[1] & st_r.pause_d); // RULE3

    //----------------------------------------------------------------
    // time base divider
    //----------------------------------------------------------------
    assign tb_on   = st_r.time_base_control[`IRQTB_TBC_ON];                                // RULE8
    assign tb_tick = st_r.time_base_control[`IRQTB_TBC_CK] ? (st_r.pre4 == `IRQTB_SYS_DIV)
                   : (st_r.tbclk_s[1] & ~st_r.tbclk_d);                      // RULE9
    assign tb_lim  = (TB_BASE << st_r.time_base_control[1:0]) - 16'h0001;                  // RULE10
    assign tb_ovf  = tb_on & tb_tick & (st_r.tb_cnt == tb_lim);

    // call requests in priority order
    assign req = {st_r.group_req_flag[G_MSC] & st_r.group_irq_enable[G_MSC],
                  st_r.group_req_flag[G_RMT] & st_r.group_irq_enable[G_RMT],
                  st_r.group_req_flag[G_TMR] & st_r.group_irq_enable[G_TMR], // RULE15
                  st_r.group_req_flag[G_CAP] & st_r.group_irq_enable[G_CAP], // RULE13
                  st_r.ind_flag[2] & st_r.ind_en[2],
                  st_r.group_req_flag[G_PWM] & st_r.group_irq_enable[G_PWM],
                  st_r.ind_flag[1] & st_r.ind_en[1],
                  st_r.ind_flag[0] & st_r.ind_en[0]};

    assign wr_go = st_r.aw_full & st_r.w_full & ~st_r.rsp.bvalid;
    assign wmask = lanes(st_r.w_strb);

    //----------------------------------------------------------------
    // next state
    //----------------------------------------------------------------
    always_comb begin
        logic [31:0] wd;
        logic [7:0]  ra;
        logic [31:0] rd;
        logic        rok;
        st_nxt = st_r;
        wd = st_r.w_data & wmask;
        ra = axi_req.araddr;
        rd = 32'h0000_0000;
        rok = 1'b1;
        // synchronisers
        st_nxt.fault_s = {st_r.fault_s[0], fault_pin_n};
        st_nxt.pause_s = {st_r.pause_s[0], pause_pin};
        st_nxt.rx_s    = {st_r.rx_s[0], remote_rx_pin};
        st_nxt.lowv_s  = {st_r.lowv_s[0], low_supply_det};
        st_nxt.tbclk_s = {st_r.tbclk_s[0], dedicated_timebase_clock};
        st_nxt.pause_d = st_r.pause_s[1];
        st_nxt.rx_d    = st_r.rx_s[1];
        st_nxt.lowv_d  = st_r.lowv_s[1];
        st_nxt.tbclk_d = st_r.tbclk_s[1];
        st_nxt.pre4    = st_r.pre4 + 2'h1;

        // divider
        if (!tb_on) begin
            st_nxt.tb_cnt = 16'h0000;                                        // RULE24
        end else if (tb_tick) begin
            st_nxt.tb_cnt = tb_ovf ? 16'h0000 : st_r.tb_cnt + 16'h0001;      // RULE10
        end

        // bus write channel capture
        if (axi_req.awvalid && st_r.rsp.awready) begin
            st_nxt.aw_full = 1'b1;
            st_nxt.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && st_r.rsp.wready) begin
            st_nxt.w_full = 1'b1;
            st_nxt.w_data = axi_req.wdata;
            st_nxt.w_strb = axi_req.wstrb;
        end
        if (st_r.rsp.bvalid && axi_req.bready) begin
            st_nxt.rsp.bvalid = 1'b0;
        end
        if (wr_go) begin
            st_nxt.aw_full = 1'b0;
            st_nxt.w_full = 1'b0;
            st_nxt.rsp.bvalid = 1'b1;
            st_nxt.rsp.bresp = `IRQTB_RESP_OK;
            case (st_r.aw_addr)
                `IRQTB_OFS_CTRL: begin
                    st_nxt.global_master_enable = (st_r.global_master_enable & ~wmask[0])
                                                | wd[0];
                    st_nxt.ind_en = (st_r.ind_en & ~wmask[3:1]) | wd[3:1];
                    st_nxt.pause_mode = (st_r.pause_mode & ~wmask[5:4]) | wd[5:4];
                end
                `IRQTB_OFS_GRP_EN: begin
                    st_nxt.group_irq_enable = (st_r.group_irq_enable & ~wmask[4:0]) | wd[4:0];
                end
                `IRQTB_OFS_SRC_EN: begin
                    st_nxt.src_en = (st_r.src_en & ~wmask) | wd;
                end
                `IRQTB_OFS_SRC_FL: begin
                    st_nxt.src_flag = st_r.src_flag & ~wd;                   // RULE16 RULE18
                end
                `IRQTB_OFS_STATUS: begin
                    st_nxt.ind_flag = st_r.ind_flag & ~wd[2:0];
                    st_nxt.group_req_flag = st_r.group_req_flag & ~wd[7:3];
                end
                `IRQTB_OFS_TBC: begin
                    st_nxt.time_base_control = (st_r.time_base_control & ~wmask[7:4]) | wd[7:4];
                end
                `IRQTB_OFS_CALL: begin
                end
                default: begin
                    st_nxt.rsp.bresp = `IRQTB_RESP_ERR;
                end
            endcase
        end
        st_nxt.rsp.awready = ~st_nxt.aw_full;
        st_nxt.rsp.wready = ~st_nxt.w_full;

        // bus read channel
        if (st_r.rsp.rvalid && axi_req.rready) begin
            st_nxt.rsp.rvalid = 1'b0;
        end
        case (ra)
            `IRQTB_OFS_CTRL:   rd = {26'h0, st_r.pause_mode, st_r.ind_en,
                                     st_r.global_master_enable};
            `IRQTB_OFS_GRP_EN: rd = {27'h0, st_r.group_irq_enable};
            `IRQTB_OFS_SRC_EN: rd = st_r.src_en;
            `IRQTB_OFS_SRC_FL: rd = st_r.src_flag;
            `IRQTB_OFS_STATUS: rd = {24'h0, st_r.group_req_flag, st_r.ind_flag};
            `IRQTB_OFS_TBC:    rd = {24'h0, st_r.time_base_control, 4'h0};                 // RULE11
            `IRQTB_OFS_CALL:   rd = {24'h0, st_r.call, 1'b0, st_r.call_vec};
            default:           rok = 1'b0;
        endcase
        if (axi_req.arvalid && st_r.rsp.arready) begin
            st_nxt.rsp.rvalid = 1'b1;
            st_nxt.rsp.rdata = rd;
            st_nxt.rsp.rresp = rok ? `IRQTB_RESP_OK : `IRQTB_RESP_ERR;
        end
        st_nxt.rsp.arready = ~st_nxt.rsp.rvalid;

        // vectored call and service
        if (reti) begin
            st_nxt.global_master_enable = 1'b1;
        end
        if (st_r.call && svc_ack) begin
            st_nxt.call = 1'b0;
            st_nxt.global_master_enable = 1'b0;                              // RULE2 RULE4
            case (st_r.call_idx)
                3'h0: st_nxt.ind_flag[0] = 1'b0;                             // RULE2
                3'h1: st_nxt.ind_flag[1] = 1'b0;                             // RULE4
                3'h2: st_nxt.group_req_flag[G_PWM] = 1'b0;                   // RULE6
                3'h3: st_nxt.ind_flag[2] = 1'b0;                             // RULE7
                3'h4: st_nxt.group_req_flag[G_CAP] = 1'b0;                   // RULE13
                3'h5: st_nxt.group_req_flag[G_TMR] = 1'b0;
                3'h6: st_nxt.group_req_flag[G_RMT] = 1'b0;
                default: st_nxt.group_req_flag[G_MSC] = 1'b0;
            endcase
        end else if (!st_r.call && st_r.global_master_enable && !stack_full && |req) begin
            st_nxt.call = 1'b1;                                              // RULE4 RULE15
            st_nxt.call_idx = pick(req);
            st_nxt.call_vec = VEC[6*pick(req) +: 6];
        end

        // sets win over every clear
        st_nxt.src_flag = st_nxt.src_flag | src_set;                         // RULE23
        st_nxt.group_req_flag = st_nxt.group_req_flag | grp_set;
        if (!st_r.fault_s[1]) begin
            st_nxt.ind_flag[0] = 1'b1;                                       // RULE1
        end
        if (pause_edge) begin
            st_nxt.ind_flag[1] = 1'b1;                                       // RULE3
        end
        if (tb_ovf) begin
            st_nxt.ind_flag[2] = 1'b1;                                       // RULE7
        end
    end

    //----------------------------------------------------------------
    // state register
    //----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.fault_s <= 2'h3;
            st_r.time_base_control <= `IRQTB_TBC_RST;
            st_r.rsp.awready <= 1'b1;
            st_r.rsp.wready <= 1'b1;
            st_r.rsp.arready <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign axi_rsp    = st_r.rsp;
    assign irq_call   = st_r.call;
    assign irq_vector = st_r.call_vec;

    // read address hits time base control, for the reserved-bit check
    logic ra_is_tbc;
    assign ra_is_tbc = axi_req.arvalid && st_r.rsp.arready && axi_req.araddr == `IRQTB_OFS_TBC;

    //----------------------------------------------------------------
    // checks
    //----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_ack;
        st_r.call && svc_ack;
    endsequence

    fault_level_set_a: assert property (!st_r.fault_s[1] |=> st_r.ind_flag[0]) // RULE1
        else $error("fault flag not set on low pin");
    ack_clears_master_a: assert property (s_ack and !reti |=> !st_r.global_master_enable
                                          && !st_r.call) // RULE2
        else $error("service left master enable set");
    pause_edge_flag_a: assert property (pause_edge |=> st_r.ind_flag[1]) // RULE3
        else $error("pause edge lost");
    call_gate_a: assert property ($rose(st_r.call) |-> $past(st_r.global_master_enable)
                                  && !$past(stack_full)) // RULE4
        else $error("call raised without permission");
    src_kept_a: assert property (s_ack and !(wr_go && st_r.aw_addr == `IRQTB_OFS_SRC_FL)
                                 |=> ($past(st_r.src_flag) & ~st_r.src_flag) == 32'h0) // RULE6
        else $error("service cleared a source flag");
    tb_ovf_flag_a: assert property (tb_ovf |=> st_r.ind_flag[2] && st_r.tb_cnt == 16'h0000) // RULE7
        else $error("time base overflow missed");
    tb_off_zero_a: assert property (!tb_on |=> st_r.tb_cnt == 16'h0000) // RULE24
        else $error("divider not held at zero");
    tb_limit_a: assert property (tb_on |-> st_r.tb_cnt <= tb_lim) // RULE10
        else $error("divider passed its period");
    tbc_low_zero_a: assert property (st_r.rsp.rvalid && $past(ra_is_tbc)
                                     |-> st_r.rsp.rdata[3:0] == 4'h0) // RULE11
        else $error("reserved control bits read nonzero");
    flag_sticky_a: assert property (st_r.ind_flag[2] && !wr_go
                                    && !(st_r.call && svc_ack && st_r.call_idx == 3'h3)
                                    |=> st_r.ind_flag[2]) // RULE23
        else $error("time base flag dropped");

    sequence s_pwm_evt;
        evt.pwm_duty_match && st_r.src_en[`IRQTB_SRC_PWMD];
    endsequence
    sequence s_cap_evt;
        evt.capture_overflow && st_r.src_en[`IRQTB_SRC_CAPO];
    endsequence

    pwm_group_set_a: assert property (s_pwm_evt |=> st_r.group_req_flag[G_PWM]) // RULE5
        else $error("pwm match lost");
    cap_group_set_a: assert property (s_cap_evt |=> st_r.group_req_flag[G_CAP]) // RULE12
        else $error("capture event lost");
    rx_rise_flag_a: assert property (st_r.rx_s[1] && !st_r.rx_d // RULE17
                                     |=> st_r.src_flag[`IRQTB_SRC_RRISE])
        else $error("remote rise lost");
    cap_call_gate_a: assert property ($rose(st_r.call) && st_r.call_idx == 3'h4 // RULE13
                                      |-> $past(st_r.group_irq_enable[G_CAP]))
        else $error("capture call without group enable");
    tb_sys_tick_a: assert property (tb_on && st_r.time_base_control[`IRQTB_TBC_CK] // RULE9
                                    && st_r.pre4 != `IRQTB_SYS_DIV |=> $stable(st_r.tb_cnt))
        else $error("divider moved off its tick");
endmodule

//--- tb/irqtb_cpu_model.sv
/*
 CPU sequencer model: takes each vectored call once, promptly or slowly.
 Assumes irq_call and irq_vector stand until svc_ack is taken.
*/
`timescale 1ns/1ps
module irqtb_cpu_model (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       irq_call,
    input  wire logic [5:0] irq_vector,
    input  wire logic       slow,
    output logic            svc_ack,
    output logic [5:0]      last_vec,
    output logic [7:0]      n_ack
);
    logic [3:0] wait_r;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            svc_ack <= 1'b0;
            last_vec <= 6'h00;
            n_ack <= 8'h00;
            wait_r <= 4'h0;
        end else begin
            svc_ack <= 1'b0;
            if (irq_call && !svc_ack) begin
                wait_r <= wait_r + 4'h1;
                if (wait_r >= (slow ? 4'h6 : 4'h0)) begin
                    svc_ack <= 1'b1;
                    last_vec <= irq_vector;
                    n_ack <= n_ack + 8'h01;
                    wait_r <= 4'h0;
                end
            end
        end
    end
endmodule

//--- tb/irqtb_top_test.sv
/*
 Register-level tests of the interrupt collector and time base.
 Assumes the CPU model acks every call; time base shortened to 16 ticks.
*/
`timescale 1ns/1ps
module irqtb_top_test
    import irqtb_pkg::*;
;
    logic core_clk, rst_n, fault_pin_n, pause_pin, remote_rx_pin, low_supply_det;
    logic tbclk, stack_full, slow, svc_ack, irq_call, reti;
    logic [4:0] tmr_p, tmr_a;
    logic [5:0] irq_vector, last_vec;
    logic [7:0] n_ack, n_seen;
    logic [31:0] rdata;
    logic [1:0] resp;
    irqtb_axi_req_t axi_req;
    irqtb_axi_rsp_t axi_rsp;
    irqtb_evt_t evt;
    int n_mismatch, cmp_count;
    int sbit [10] = '{0, 1, 2, 3, 6, 7, 18, 28, 4, 8};
    int grp [10] = '{0, 0, 1, 1, 3, 4, 2, 2, 3, 4};
    logic [5:0] vec [10] = '{6'h20, 6'h20, 6'h28, 6'h28, 6'h34, 6'h3C, 6'h2C, 6'h2C, 6'h34, 6'h3C};

    irqtb_top #(.TB_BASE(16'h0010)) dut_u (.core_clk(core_clk), .rst_n(rst_n),
        .axi_req(axi_req), .axi_rsp(axi_rsp), .fault_pin_n(fault_pin_n),
        .pause_pin(pause_pin), .remote_rx_pin(remote_rx_pin), .low_supply_det(low_supply_det),
        .dedicated_timebase_clock(tbclk), .evt(evt), .timer_period_match(tmr_p),
        .timer_second_match(tmr_a), .stack_full(stack_full), .svc_ack(svc_ack),
        .reti(reti), .irq_call(irq_call), .irq_vector(irq_vector));
    irqtb_cpu_model cpu_u (.core_clk(core_clk), .rst_n(rst_n), .irq_call(irq_call),
        .irq_vector(irq_vector), .slow(slow), .svc_ack(svc_ack), .last_vec(last_vec),
        .n_ack(n_ack));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial begin
        tbclk = 1'b0;
        forever #40 tbclk = ~tbclk;
    end
    // ----------------------------------------
    // bus tasks and comparison
    // ----------------------------------------
    task automatic final_report();
        if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        {axi_req.awvalid, axi_req.wvalid, axi_req.bready} <= 3'h7;
        {axi_req.awaddr, axi_req.wdata, axi_req.wstrb} <= {a, d, 4'hF};
        do begin
            @(posedge core_clk);
            if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
            if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
        end while (axi_rsp.bvalid !== 1'b1);
        axi_req.bready <= 1'b0;
        chk({30'h0, axi_rsp.bresp}, 32'h0);
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        {axi_req.arvalid, axi_req.araddr, axi_req.rready} <= {1'b1, a, 1'b1};
        do begin
            @(posedge core_clk);
            if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
        end while (axi_rsp.rvalid !== 1'b1);
        axi_req.rready <= 1'b0;
        rdata = axi_rsp.rdata;
        resp = axi_rsp.rresp;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        rd(a);
        chk(rdata & m, e);
    endtask
    task automatic wait_call(input logic [5:0] v);
        while (n_ack === n_seen) @(posedge core_clk);
        n_seen = n_ack;
        chk({26'h0, last_vec}, {26'h0, v});
        repeat (2) @(posedge core_clk);
    endtask
    task automatic pulse(input int k);
        @(posedge core_clk);
        if (k < 6) evt <= irqtb_evt_t'(6'h20 >> k);
        else if (k == 6) tmr_p[2] <= 1'b1;
        else if (k == 7) tmr_a[4] <= 1'b1;
        else if (k == 8) remote_rx_pin <= 1'b1;
        else low_supply_det <= 1'b1;
        repeat (k > 7 ? 5 : 1) @(posedge core_clk);
        {evt, tmr_p, tmr_a, remote_rx_pin, low_supply_det} <= '0;
        repeat (5) @(posedge core_clk);
    endtask
    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        final_report();
    end
    initial begin
        {rst_n, reti, stack_full, slow, pause_pin, remote_rx_pin, low_supply_det} = '0;
        {axi_req, evt, tmr_p, tmr_a, n_seen, n_mismatch, cmp_count} = '0;
        fault_pin_n = 1'b1;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        rdchk(8'h14, 32'hFFFF_FFFF, 32'h30);
        wr(8'h14, 32'hFF);
        rdchk(8'h14, 32'hFFFF_FFFF, 32'hF0);
        rd(8'h40);
        chk({30'h0, resp}, 32'h2);
        fault_pin_n <= 1'b0;
        repeat (6) @(posedge core_clk);
        fault_pin_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        rdchk(8'h10, 32'h1, 32'h1);
        wr(8'h00, 32'h3);
        wait_call(6'h18);
        rdchk(8'h10, 32'h1, 32'h0);
        rdchk(8'h00, 32'h1, 32'h0);
        reti <= 1'b1;
        @(posedge core_clk);
        reti <= 1'b0;
        rdchk(8'h00, 32'h1, 32'h1);
        for (int m = 1; m < 4; m++) begin
            wr(8'h00, 32'(m) << 4);
            pause_pin <= 1'b1;
            repeat (5) @(posedge core_clk);
            rdchk(8'h10, 32'h2, 32'(m & 1) << 1);
            wr(8'h10, 32'h2);
            pause_pin <= 1'b0;
            repeat (5) @(posedge core_clk);
            rdchk(8'h10, 32'h2, 32'(m & 2));
            wr(8'h10, 32'h2);
        end
        stack_full <= 1'b1;
        wr(8'h00, 32'h15);
        pause_pin <= 1'b1;
        repeat (40) @(posedge core_clk);
        chk({24'h0, n_ack}, {24'h0, n_seen});
        stack_full <= 1'b0;
        wait_call(6'h1C);
        rdchk(8'h10, 32'h2, 32'h0);
        for (int k = 0; k < 10; k++) begin
            slow <= k[0];
            wr(8'h08, 32'h1 << sbit[k]);
            wr(8'h04, 32'h1 << grp[k]);
            pulse(k);
            rdchk(8'h0C, 32'h1 << sbit[k], 32'h1 << sbit[k]);
            wr(8'h00, 32'h1);
            wait_call(vec[k]);
            rdchk(8'h00, 32'h1, 32'h0);
            rdchk(8'h10, 32'h8 << grp[k], 32'h0);
            rdchk(8'h0C, 32'h1 << sbit[k], 32'h1 << sbit[k]);
            wr(8'h0C, 32'hFFFF_FFFF);
            rdchk(8'h0C, 32'hFFFF_FFFF, 32'h0);
        end
        for (int i = 0; i < 5; i++) begin
            wr(8'h14, 32'h0);
            wr(8'h10, 32'h4);
            wr(8'h14, i < 4 ? 32'hC0 | (32'(i) << 4) : 32'h80);
            repeat ((i < 4 ? 64 << i : 256) - 40) @(posedge core_clk);
            rdchk(8'h10, 32'h4, 32'h0);
            repeat (80) @(posedge core_clk);
            rdchk(8'h10, 32'h4, 32'h4);
        end
        wr(8'h00, 32'h9);
        wait_call(6'h24);
        rdchk(8'h10, 32'h4, 32'h0);
        wr(8'h14, 32'h40);
        wr(8'h10, 32'h4);
        repeat (300) @(posedge core_clk);
        rdchk(8'h10, 32'h4, 32'h0);
        final_report();
    end
endmodule
